// ===== hw/fcg_regs.svh
`ifndef FCG_REGS_SVH
`define FCG_REGS_SVH

// register byte offsets
`define FCG_OFF_CTRL 8'h00
`define FCG_OFF_CMD 8'h04
`define FCG_OFF_STATUS 8'h08
`define FCG_OFF_RESULT 8'h0C
`define FCG_OFF_HARM 8'h10

// reset values
`define FCG_CTRL_RST 8'h00
`define FCG_RESULT_RST 32'h0000_0000

// command bits
`define FCG_CMD_RESET 0
`define FCG_CMD_CLR_READY 1

// status bit positions
`define FCG_ST_READY 3
`define FCG_ST_OVF 4
`define FCG_ST_HWAIT 5

// timing
`define FCG_CLK_MHZ 20
`define FCG_REF_MHZ 10
`define FCG_GATE_US 1000
`define FCG_GATE_EDGES (`FCG_GATE_US * `FCG_REF_MHZ)
`define FCG_MS_US 1000
`define FCG_MS_CYC (`FCG_MS_US * `FCG_CLK_MHZ)
`define FCG_SCAN_US 100
`define FCG_SCAN_CYC (`FCG_SCAN_US * `FCG_CLK_MHZ)
`define FCG_HOLD1_MS 10'd10
`define FCG_HOLD2_MS 10'd100
`define FCG_HOLD3_MS 10'd1000

// dividers and harmonic translation
`define FCG_PRE_RATIO 4
`define FCG_DIV_LAST 4'h9
`define FCG_HARM_MHZ 200
`define FCG_HARM_DIGIT 4

`endif

// ===== hw/fcg_pkg.sv
package fcg_pkg;

    typedef enum logic [2:0] {
        FCG_IDLE  = 3'b000,
        FCG_ARM   = 3'b001,
        FCG_GATE  = 3'b010,
        FCG_LATCH = 3'b011,
        FCG_HOLD  = 3'b100
    } fcg_state_t;

    typedef enum logic [1:0] {
        FCG_DIRECT_BAND     = 2'b00,
        FCG_PRESCALED_BAND  = 2'b01,
        FCG_HETERODYNE_BAND = 2'b10,
        FCG_SPARE_BAND      = 2'b11
    } fcg_band_t;

    typedef struct packed {
        logic remote;
        logic [1:0] rate;
        logic test;
        logic ref_ext;
        fcg_band_t band;
        logic run;
    } fcg_ctrl_t;

    typedef struct packed {
        logic write;
        logic [7:0] addr;
    } fcg_ahb_req_t;

endpackage

// ===== hw/fcg_count_chain.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcg_regs.svh"
module fcg_count_chain
    import fcg_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic load,
    input wire logic [31:0] load_val,
    input wire logic inc,
    output logic [31:0] digits,
    output logic carry_out
);
    logic [8:0] carry;

    assign carry[0] = inc;
    assign carry_out = carry[8];

    // one decade per digit, ripple carry between them
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_dec
            logic [3:0] digit_q;
            logic [3:0] digit_d;
            assign carry[i + 1] = carry[i] & (digit_q == `FCG_DIV_LAST);
            assign digits[4 * i +: 4] = digit_q;
            // load beats increment so a preset is never disturbed
            always_comb begin
                digit_d = digit_q;
                if (load) begin
                    digit_d = load_val[4 * i +: 4];
                end else if (carry[i]) begin
                    digit_d = (digit_q == `FCG_DIV_LAST) ? 4'h0 : 4'(digit_q + 4'h1);
                end
            end
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    digit_q <= 4'h0;
                end else begin
                    digit_q <= digit_d;
                end
            end
        end
    endgenerate
endmodule // fcg_count_chain
`default_nettype wire

// ===== hw/fcg_top.sv
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "fcg_regs.svh"
module fcg_top
    import fcg_pkg::*;
#(
    parameter int unsigned GATE_REF_EDGES = `FCG_GATE_EDGES,
    parameter int unsigned MS_CYCLES = `FCG_MS_CYC
) (
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    input wire logic REF_INT,
    input wire logic REF_EXT,
    input wire logic SIG_DIRECT,
    input wire logic SIG_PRESCALED_BAND,
    input wire logic SIG_HETERODYNE_BAND,
    input wire logic [7:0] CONV_HARM,
    input wire logic CONV_HARM_VALID,
    input wire logic PANEL_TEST,
    input wire logic PANEL_RESET,
    input wire logic [1:0] PANEL_RATE,
    output logic GATE_OPEN,
    output logic [3:0] DISP_DIGIT,
    output logic [2:0] DISP_SEL
);
    localparam logic [17:0] GATE_1 = 18'(GATE_REF_EDGES);
    localparam logic [17:0] GATE_4 = 18'(GATE_REF_EDGES * `FCG_PRE_RATIO);
    localparam logic [14:0] MS_LAST = 15'(MS_CYCLES - 1);
    localparam logic [11:0] SCAN_LAST = 12'(`FCG_SCAN_CYC - 1);

    // binary to packed bcd, three digits
    function automatic logic [11:0] fcg_bin2bcd(input logic [8:0] bin);
        logic [11:0] bcd;
        bcd = 12'h000;
        for (int k = 8; k >= 0; k--) begin
            if (bcd[3:0] > 4'h4) bcd[3:0] = 4'(bcd[3:0] + 4'h3);
            if (bcd[7:4] > 4'h4) bcd[7:4] = 4'(bcd[7:4] + 4'h3);
            if (bcd[11:8] > 4'h4) bcd[11:8] = 4'(bcd[11:8] + 4'h3);
            bcd = {bcd[10:0], bin[k]};
        end
        return bcd;
    endfunction

    // ---------------- bus slave state ----------------
    fcg_ctrl_t ctrl_q, ctrl_d;
    fcg_ahb_req_t req_q, req_d;
    logic wr_pend_q, wr_pend_d;
    logic rd_pend_q, rd_pend_d;
    logic hready_q, hready_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic cmd_reset, cmd_clr_ready;

    // ---------------- measurement state ----------------
    fcg_state_t state_q, state_d;
    logic [17:0] gate_cnt_q, gate_cnt_d;
    logic [9:0] hold_cnt_q, hold_cnt_d;
    logic [14:0] ms_cnt_q, ms_cnt_d;
    logic [3:0] div_q, div_d;
    logic [1:0] pre_q, pre_d;
    logic pre_in_q, sig_prev_q, ref_prev_q, prst_prev_q;
    logic [31:0] result_q, result_d;
    logic [7:0] harm_q, harm_d;
    logic ready_q, ready_d, ovf_q, ovf_d, run_ovf_q, run_ovf_d;
    logic gate_q, gate_d;
    logic [11:0] scan_cnt_q, scan_cnt_d;
    logic [2:0] sel_q, sel_d;
    logic [3:0] digit_q, digit_d;

    logic ref_edge, sig_sel, shaped, div_pulse, chain_inc, chain_load, chain_carry;
    logic eff_test, do_reset, het_band, harm_wait, ms_tick;
    logic [1:0] eff_rate;
    logic [9:0] hold_tgt;
    logic [17:0] gate_tgt;
    logic [31:0] chain_val, load_val;

    // panel controls only count while the unit is under local control
    assign eff_test = ctrl_q.remote ? ctrl_q.test : PANEL_TEST;
    assign eff_rate = ctrl_q.remote ? ctrl_q.rate : PANEL_RATE;
    assign do_reset = cmd_reset | (~ctrl_q.remote & PANEL_RESET & ~prst_prev_q);
    assign het_band = (ctrl_q.band == FCG_HETERODYNE_BAND);
    assign harm_wait = (state_q == FCG_ARM) & het_band & ~CONV_HARM_VALID;

    // ---------------- ahb-lite slave ----------------
    // reads take one wait state so a write just before is already visible
    always_comb begin
        req_d = req_q;
        wr_pend_d = 1'b0;
        rd_pend_d = 1'b0;
        hready_d = 1'b1;
        hrdata_d = hrdata_q;
        ctrl_d = ctrl_q;
        cmd_reset = 1'b0;
        cmd_clr_ready = 1'b0;
        if (HSEL && HTRANS[1] && HREADY) begin
            req_d = '{write: HWRITE, addr: HADDR[7:0]};
            wr_pend_d = HWRITE;
            rd_pend_d = ~HWRITE;
            hready_d = HWRITE;
        end
        if (wr_pend_q) begin
            case (req_q.addr)
                `FCG_OFF_CTRL: ctrl_d = fcg_ctrl_t'(HWDATA[7:0]);
                `FCG_OFF_CMD: begin
                    cmd_reset = HWDATA[`FCG_CMD_RESET];
                    cmd_clr_ready = HWDATA[`FCG_CMD_CLR_READY];
                end
                default: ;
            endcase
        end
        if (rd_pend_q) begin
            case (req_q.addr)
                `FCG_OFF_CTRL: hrdata_d = {24'h000000, ctrl_q};
                `FCG_OFF_STATUS: hrdata_d = {26'h0000000, harm_wait, ovf_q, ready_q, state_q};
                `FCG_OFF_RESULT: hrdata_d = result_q;
                `FCG_OFF_HARM: hrdata_d = {24'h000000, harm_q};
                default: hrdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            req_q <= '0;
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            hready_q <= 1'b1;
            hrdata_q <= 32'h0000_0000;
            ctrl_q <= fcg_ctrl_t'(`FCG_CTRL_RST);
        end else begin
            req_q <= req_d;
            wr_pend_q <= wr_pend_d;
            rd_pend_q <= rd_pend_d;
            hready_q <= hready_d;
            hrdata_q <= hrdata_d;
            ctrl_q <= ctrl_d;
        end
    end

    assign HREADYOUT = hready_q;
    assign HRESP = 1'b0;
    assign HRDATA = hrdata_q;

    // ---------------- signal path ----------------
    // inputs must toggle below SYS_CLK/2 or edges are lost
    assign ref_edge = (ctrl_q.ref_ext ? REF_EXT : REF_INT) & ~ref_prev_q;
    assign pre_d = (SIG_PRESCALED_BAND & ~pre_in_q) ? 2'(pre_q + 2'h1) : pre_q;

    // test mode counts the reference itself as a self check
    always_comb begin
        case (ctrl_q.band)
            FCG_PRESCALED_BAND: sig_sel = pre_q[1];
            FCG_HETERODYNE_BAND: sig_sel = SIG_HETERODYNE_BAND;
            default: sig_sel = SIG_DIRECT;
        endcase
        if (eff_test) begin
            sig_sel = ctrl_q.ref_ext ? REF_EXT : REF_INT;
        end
    end

    assign shaped = sig_sel & ~sig_prev_q;
    assign div_pulse = shaped & (div_q == `FCG_DIV_LAST);
    assign chain_inc = (state_q == FCG_GATE) & div_pulse;

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pre_q <= 2'h0;
            pre_in_q <= 1'b0;
            sig_prev_q <= 1'b0;
            ref_prev_q <= 1'b0;
            prst_prev_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            pre_in_q <= SIG_PRESCALED_BAND;
            sig_prev_q <= sig_sel;
            ref_prev_q <= ctrl_q.ref_ext ? REF_EXT : REF_INT;
            prst_prev_q <= PANEL_RESET;
        end
    end

    // ---------------- count chain ----------------
    // one chain count is 10 kHz, so a 200 MHz step is 2 at digit 4
    assign load_val = het_band ?
        {4'h0, fcg_bin2bcd({1'b0, CONV_HARM} << 1), 16'h0000} : 32'h0000_0000;
    assign chain_load = (state_q == FCG_ARM) | do_reset;

    fcg_count_chain u_chain (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .load(chain_load),
        .load_val(load_val),
        .inc(chain_inc),
        .digits(chain_val),
        .carry_out(chain_carry)
    );

    // ---------------- measurement sequencer ----------------
    // prescaled band keeps the gate open four times longer
    assign gate_tgt = (ctrl_q.band == FCG_PRESCALED_BAND) ? GATE_4 : GATE_1;
    assign ms_tick = (ms_cnt_q == MS_LAST);

    always_comb begin
        case (eff_rate)
            2'h1: hold_tgt = `FCG_HOLD1_MS;
            2'h2: hold_tgt = `FCG_HOLD2_MS;
            2'h3: hold_tgt = `FCG_HOLD3_MS;
            default: hold_tgt = 10'h000;
        endcase
    end

    always_comb begin
        state_d = state_q;
        gate_cnt_d = gate_cnt_q;
        hold_cnt_d = hold_cnt_q;
        ms_cnt_d = 15'h0000;
        div_d = div_q;
        result_d = result_q;
        harm_d = harm_q;
        ovf_d = ovf_q;
        run_ovf_d = run_ovf_q | chain_inc & chain_carry;
        ready_d = ready_q & ~cmd_clr_ready;
        if (shaped) begin
            div_d = (div_q == `FCG_DIV_LAST) ? 4'h0 : 4'(div_q + 4'h1);
        end
        case (state_q)
            FCG_IDLE: begin
                if (ctrl_q.run) state_d = FCG_ARM;
            end
            FCG_ARM: begin
                // chain is reloaded every cycle here, residue cleared
                div_d = 4'h0;
                gate_cnt_d = 18'h00000;
                run_ovf_d = 1'b0;
                harm_d = het_band ? CONV_HARM : 8'h00;
                if (!ctrl_q.run) begin
                    state_d = FCG_IDLE;
                end else if (ref_edge && !harm_wait) begin
                    state_d = FCG_GATE;
                end
            end
            FCG_GATE: begin
                if (ref_edge) begin
                    gate_cnt_d = 18'(gate_cnt_q + 18'h00001);
                    if (gate_cnt_d == gate_tgt) state_d = FCG_LATCH;
                end
            end
            FCG_LATCH: begin
                result_d = chain_val;
                ovf_d = run_ovf_q;
                ready_d = 1'b1;
                hold_cnt_d = 10'h000;
                state_d = (hold_tgt == 10'h000) ? FCG_ARM : FCG_HOLD;
            end
            FCG_HOLD: begin
                ms_cnt_d = ms_tick ? 15'h0000 : 15'(ms_cnt_q + 15'h0001);
                if (ms_tick) hold_cnt_d = 10'(hold_cnt_q + 10'h001);
                if (!ctrl_q.run) begin
                    state_d = FCG_IDLE;
                end else if (hold_cnt_q >= hold_tgt) begin
                    state_d = FCG_ARM;
                end
            end
            default: state_d = FCG_IDLE;
        endcase
        if (do_reset) begin
            state_d = FCG_IDLE;
            div_d = 4'h0;
        end
    end

    // gate output follows the state it will be in
    assign gate_d = (state_d == FCG_GATE);

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= FCG_IDLE;
            gate_cnt_q <= 18'h00000;
            hold_cnt_q <= 10'h000;
            ms_cnt_q <= 15'h0000;
            div_q <= 4'h0;
            result_q <= `FCG_RESULT_RST;
            harm_q <= 8'h00;
            ovf_q <= 1'b0;
            run_ovf_q <= 1'b0;
            ready_q <= 1'b0;
            gate_q <= 1'b0;
        end else begin
            state_q <= state_d;
            gate_cnt_q <= gate_cnt_d;
            hold_cnt_q <= hold_cnt_d;
            ms_cnt_q <= ms_cnt_d;
            div_q <= div_d;
            result_q <= result_d;
            harm_q <= harm_d;
            ovf_q <= ovf_d;
            run_ovf_q <= run_ovf_d;
            ready_q <= ready_d;
            gate_q <= gate_d;
        end
    end

    assign GATE_OPEN = gate_q;

    // ---------------- display multiplex ----------------
    // stored digits only, never the running chain
    always_comb begin
        scan_cnt_d = 12'(scan_cnt_q + 12'h001);
        sel_d = sel_q;
        if (scan_cnt_q == SCAN_LAST) begin
            scan_cnt_d = 12'h000;
            sel_d = 3'(sel_q + 3'h1);
        end
        digit_d = result_q[{sel_d, 2'b00} +: 4];
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            scan_cnt_q <= 12'h000;
            sel_q <= 3'h0;
            digit_q <= 4'h0;
        end else begin
            scan_cnt_q <= scan_cnt_d;
            sel_q <= sel_d;
            digit_q <= digit_d;
        end
    end

    assign DISP_SEL = sel_q;
    assign DISP_DIGIT = digit_q;
endmodule // fcg_top
`default_nettype wire

// ===== test/fcg_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fcg_asserts #(
    parameter int unsigned GATE_REF_EDGES = 10000,
    parameter int unsigned MS_CYCLES = 20000
) (
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [31:0] HRDATA,
    input wire logic REF_INT,
    input wire logic REF_EXT,
    input wire logic PANEL_RESET,
    input wire logic GATE_OPEN,
    input wire logic [3:0] DISP_DIGIT,
    input wire logic [2:0] DISP_SEL
);
    localparam int unsigned G = GATE_REF_EDGES;
    logic rd_tk, wr_tk, ri_q, re_q, ab_q;
    logic [15:0] ni_q, ne_q;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    assign rd_tk = HSEL && HTRANS[1] && HREADY && !HWRITE;
    assign wr_tk = HSEL && HTRANS[1] && HREADY && HWRITE;
    // reference edges seen while the gate is open; aborted gates are marked
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ri_q <= 1'h0;
            re_q <= 1'h0;
            ab_q <= 1'h0;
            ni_q <= 16'h0;
            ne_q <= 16'h0;
        end else begin
            ri_q <= REF_INT;
            re_q <= REF_EXT;
            ab_q <= GATE_OPEN && (ab_q || PANEL_RESET || wr_tk);
            ni_q <= GATE_OPEN ? ni_q + 16'(REF_INT && !ri_q) : 16'h0;
            ne_q <= GATE_OPEN ? ne_q + 16'(REF_EXT && !re_q) : 16'h0;
        end
    end
    a_resp_okay: assert property (HRESP == 1'h0)
        else $error("error response seen");
    a_read_wait: assert property (rd_tk |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read not answered after one wait");
    a_write_zero: assert property (wr_tk |=> HREADYOUT)
        else $error("write stalled");
    a_wait_cause: assert property (!HREADYOUT |-> $past(rd_tk))
        else $error("wait state without a read");
    a_rdata_hold: assert property ($changed(HRDATA) |-> $past(rd_tk) || $past(rd_tk, 2))
        else $error("read data moved without a read");
    a_sel_step: assert property ($changed(DISP_SEL) |-> DISP_SEL == $past(DISP_SEL) + 3'h1)
        else $error("digit select skipped");
    a_digit_hold: assert property ($changed(DISP_DIGIT) |-> $changed(DISP_SEL) ||
        $past(GATE_OPEN, 2) || $past(GATE_OPEN, 3) || $past(GATE_OPEN, 4))
        else $error("digit changed without scan or latch");
    a_gate_min: assert property ($rose(GATE_OPEN) |-> GATE_OPEN [*8])
        else $error("gate closed too early");
    // one count of slack for where the gate edge lands against the reference
    a_gate_len: assert property ($fell(GATE_OPEN) && !ab_q |->
        ni_q inside {[G-1:G+1], [4*G-1:4*G+1]} || ne_q inside {[G-1:G+1], [4*G-1:4*G+1]})
        else $error("gate length off in reference edges");
endmodule // fcg_asserts
bind fcg_top fcg_asserts #(.GATE_REF_EDGES(GATE_REF_EDGES), .MS_CYCLES(MS_CYCLES)) u_chk (
    .SYS_CLK, .ARST_N, .HSEL, .HTRANS, .HWRITE, .HREADY, .HREADYOUT, .HRESP, .HRDATA,
    .REF_INT, .REF_EXT, .PANEL_RESET, .GATE_OPEN, .DISP_DIGIT, .DISP_SEL);
`default_nettype wire

// ===== test/fcg_partner.sv
`timescale 1ns/1ps
`default_nettype none
module fcg_partner #(
    parameter int unsigned LAT = 40
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic lock,
    input wire logic [7:0] harm,
    output logic [7:0] conv_harm,
    output logic conv_valid,
    output logic diff_sig
);
    logic [7:0] wt_q;
    logic [2:0] ph_q;
    // harmonic only valid after the slow search; invalid bus toggles every cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wt_q <= 8'h0;
            ph_q <= 3'h0;
            conv_valid <= 1'h0;
            conv_harm <= 8'h0;
        end else begin
            wt_q <= lock ? wt_q + 8'(wt_q < 8'(LAT)) : 8'h0;
            conv_valid <= lock && wt_q >= 8'(LAT);
            conv_harm <= (lock && wt_q >= 8'(LAT)) ? harm : ~conv_harm;
            ph_q <= (ph_q == 3'h4) ? 3'h0 : ph_q + 3'h1;
        end
    end
    // difference signal at a scaled rate, held low while not locked
    assign diff_sig = lock && ph_q < 3'h2;
endmodule // fcg_partner
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcg_regs.svh"
module tb_top;
    logic SYS_CLK = 1'h0, ARST_N = 1'h0, HSEL = 1'h0, HWRITE = 1'h0, lock = 1'h0;
    logic PANEL_TEST = 1'h0, PANEL_RESET = 1'h0;
    logic [1:0] HTRANS = 2'h0, PANEL_RATE = 2'h3;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd, prev = 32'h0;
    logic HREADYOUT, HRESP, GATE_OPEN, CONV_HARM_VALID, het_sig;
    logic [7:0] CONV_HARM;
    logic [3:0] DISP_DIGIT, rc = 4'h0;
    logic [2:0] DISP_SEL, sc = 3'h0;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    always #25 SYS_CLK = ~SYS_CLK;
    // references at 1/8 and 1/16 of the clock, input at 1/5, all clock-locked
    always @(posedge SYS_CLK) begin
        rc <= rc + 4'h1;
        sc <= (sc == 3'h4) ? 3'h0 : sc + 3'h1;
    end
    fcg_top #(.GATE_REF_EDGES(35), .MS_CYCLES(10)) dut (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
        .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .HRDATA(HRDATA), .REF_INT(rc[2]), .REF_EXT(rc[3]), .SIG_DIRECT(sc < 3'h2),
        .SIG_PRESCALED_BAND(sc < 3'h2), .SIG_HETERODYNE_BAND(het_sig), .CONV_HARM(CONV_HARM),
        .CONV_HARM_VALID(CONV_HARM_VALID), .PANEL_TEST(PANEL_TEST), .PANEL_RESET(PANEL_RESET),
        .PANEL_RATE(PANEL_RATE), .GATE_OPEN(GATE_OPEN), .DISP_DIGIT(DISP_DIGIT),
        .DISP_SEL(DISP_SEL));
    fcg_partner #(.LAT(40)) u_conv (.clk(SYS_CLK), .arst_n(ARST_N), .lock(lock),
        .harm(8'h25), .conv_harm(CONV_HARM), .conv_valid(CONV_HARM_VALID), .diff_sig(het_sig));
    task automatic print_verdict;
        if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // single word transfer; address held until accepted, data until answered
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        HSEL <= 1'h1;
        HADDR <= {24'h0, a};
        HTRANS <= 2'h2;
        HWRITE <= w;
        do @(posedge SYS_CLK); while (HREADYOUT !== 1'h1);
        HSEL <= 1'h0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do @(posedge SYS_CLK); while (HREADYOUT !== 1'h1);
        rd = HRDATA;
    endtask
    task automatic wgate(input logic w);
        repeat (3000) if (GATE_OPEN !== w) @(posedge SYS_CLK);
        chk({31'h0, GATE_OPEN}, {31'h0, w});
    endtask
    // long hold rate so the next cycle cannot start before run is dropped
    task automatic meas(input logic [7:0] ctrl, input logic [31:0] exp);
        bus(1'h1, `FCG_OFF_CMD, 32'h2);
        bus(1'h1, `FCG_OFF_CTRL, {24'h0, ctrl});
        wgate(1'h1);
        bus(1'h0, `FCG_OFF_RESULT, 32'h0);
        chk(rd, prev);
        wgate(1'h0);
        rd = 32'h0;
        repeat (50) if (rd[3] !== 1'h1) bus(1'h0, `FCG_OFF_STATUS, 32'h0);
        bus(1'h1, `FCG_OFF_CTRL, {24'h0, ctrl & 8'hFE});
        bus(1'h0, `FCG_OFF_RESULT, 32'h0);
        chk(rd, exp);
        prev = exp;
    endtask
    task automatic t_regs;
        bus(1'h0, `FCG_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        bus(1'h1, `FCG_OFF_CTRL, 32'hE0);
        bus(1'h0, `FCG_OFF_CTRL, 32'h0);
        chk(rd, 32'hE0);
        bus(1'h1, 8'h14, 32'hFFFF_FFFF);
        bus(1'h0, 8'h14, 32'h0);
        chk(rd, 32'h0);
        bus(1'h1, `FCG_OFF_RESULT, 32'hFFFF_FFFF);
        bus(1'h0, `FCG_OFF_RESULT, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic t_count;
        meas(8'hE1, 32'h5);
        meas(8'hE3, 32'h5);
        meas(8'hE9, 32'h11);
        meas(8'hF1, 32'h3);
        PANEL_TEST <= 1'h1;
        meas(8'h01, 32'h3);
    endtask
    // harmonic arrives late; chain preset shows through the result and display
    task automatic t_het;
        lock <= 1'h1;
        bus(1'h1, `FCG_OFF_CMD, 32'h2);
        bus(1'h1, `FCG_OFF_CTRL, 32'hE5);
        bus(1'h0, `FCG_OFF_STATUS, 32'h0);
        chk(rd, 32'h21);
        meas(8'hE5, 32'h0074_0005);
        bus(1'h0, `FCG_OFF_HARM, 32'h0);
        chk(rd, 32'h25);
        repeat (20000) if (DISP_SEL !== 3'h5) @(posedge SYS_CLK);
        chk({28'h0, DISP_DIGIT}, 32'h7);
    endtask
    // abort mid-gate from the panel, then by command; stored result survives
    task automatic t_abort;
        for (int i = 0; i < 2; i++) begin
            bus(1'h1, `FCG_OFF_CTRL, i ? 32'h81 : 32'h01);
            wgate(1'h1);
            bus(1'h1, `FCG_OFF_CTRL, i ? 32'h80 : 32'h00);
            if (i) bus(1'h1, `FCG_OFF_CMD, 32'h1);
            else PANEL_RESET <= 1'h1;
            repeat (3) @(posedge SYS_CLK);
            chk({31'h0, GATE_OPEN}, 32'h0);
            PANEL_RESET <= 1'h0;
            bus(1'h0, `FCG_OFF_STATUS, 32'h0);
            chk(rd, 32'h8);
            bus(1'h0, `FCG_OFF_RESULT, 32'h0);
            chk(rd, prev);
        end
    endtask
    always @(posedge SYS_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            print_verdict;
        end
    end
    initial begin
        repeat (4) @(posedge SYS_CLK);
        ARST_N <= 1'h1;
        @(posedge SYS_CLK);
        t_regs;
        t_count;
        t_het;
        t_abort;
        print_verdict;
    end
endmodule // tb_top
`default_nettype wire
